// ==== hw/smcg_pkg.sv ====
package smcg_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 2;
  localparam int NUM_PERIPH = 5;
  localparam int CNT_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_PRR = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 2'h2;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [NUM_PERIPH-1:0] PRR_RESET = 5'h00;
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_NOISE = 3'h1;
  localparam logic [2:0] MODE_PDOWN = 3'h2;
  localparam logic [2:0] MODE_PSAVE = 3'h3;
  localparam logic [2:0] MODE_STANDBY = 3'h6;
  localparam int CLK_PERIOD_NS = 8;
  localparam int HALT_CYCLES = 4;
  localparam int STANDBY_CYCLES = 6;
  localparam int RESTART_NS_0 = 1000;
  localparam int RESTART_NS_1 = 4000;
  localparam int RESTART_NS_2 = 16000;
  localparam int RESTART_NS_3 = 32000;
  localparam logic [CNT_W-1:0] RESTART_CYC_0 = CNT_W'((RESTART_NS_0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RESTART_CYC_1 = CNT_W'((RESTART_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RESTART_CYC_2 = CNT_W'((RESTART_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RESTART_CYC_3 = CNT_W'((RESTART_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP, ST_RESTART, ST_HALT} smcg_state_t;

  typedef struct packed {
    logic core;
    logic flash;
    logic io;
    logic conv;
    logic asy;
    logic main_osc;
    logic timer_osc;
    logic t2_disp;
  } smcg_clk_t;

  typedef struct packed {
    logic comparator_off;
    logic ref_keep;
    logic input_buf_en;
    logic wdt_run;
    logic bod_run;
    logic conv_run;
  } smcg_analog_t;

  typedef struct packed {
    smcg_state_t state;
    logic [2:0] mode;
    logic [CNT_W-1:0] count;
    logic [DATA_W-1:0] ctrl;
    logic [NUM_PERIPH-1:0] peripheral_clock_stop_register;
    logic [DATA_W-1:0] rdata;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic conv_en_prev;
    logic conv_ext;
    logic conv_start;
    logic resume;
    logic reset_wake;
    smcg_clk_t clk;
    smcg_analog_t ana;
  } smcg_regs_t;
endpackage

// ==== hw/smcg_sleep_ctrl.sv ====
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

// How it works
// RULE1: mode 000 sleep halts core and program-memory clocks, rest keeps running.
// RULE2: idle wakes on any enabled interrupt, external or internal.
// RULE3: mode 001 halts io, core and program-memory clocks; converter, async run.
// RULE4: noise mode wakes only on its listed converter, timer, pin and reset sources.
// RULE5: idle and noise mode start a conversion on entry if converter enabled.
// RULE6: mode 010 stops oscillator and generated clocks; async wake logic only.
// RULE7: power-down wakes only on reset, start condition, level line zero, pin change.
// RULE8: outside source holds a wake level long enough to be seen.
// RULE9: power-down wake waits a restart period picked by clock source fuses.
// RULE10: mode 011 is power-down but timer 2 and display keep running.
// RULE11: power-save wakes on enabled timer-2 events with global enable, or display.
// RULE12: power-save stops unused timer and main oscillators; sync clock only for them.
// RULE13: mode 110 with crystal enters standby, oscillator kept running.
// RULE14: standby wakes after six clock cycles.
// RULE15: setting a peripheral stop bit stops its clock and blocks its registers.
// RULE16: clearing the stop bit restarts the clock with state untouched.
// RULE17: peripheral stop bits act in active and idle; deeper modes stop anyway.
// RULE18: converter stays enabled in sleep; re-enable forces an extended conversion.
// RULE19: comparator auto-disabled in deep modes; reference kept if comparator uses it.
// RULE20: enabled watchdog and brown-out detector stay enabled in every mode.
// RULE21: input buffers off when io and converter clocks both stop.
// RULE22: debug enable keeps main clock running in power-down and power-save.
// RULE23: core sets sleep enable then executes sleep; without enable no sleep.
// RULE24: interrupt wake halts core four cycles past start-up; reset restarts.
// RULE25: mode codes 100, 101 and 111 are reserved and never enter sleep.
module smcg_sleep_ctrl (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [smcg_pkg::ADDR_W-1:0] i_addr,
  input wire logic [smcg_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [smcg_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_sleep_exec,
  input wire logic i_irq_any,
  input wire logic i_conv_done,
  input wire logic i_display_irq,
  input wire logic i_start_cond,
  input wire logic i_timer2_ovf,
  input wire logic i_timer2_cmp,
  input wire logic [1:0] i_timer2_interrupt_mask,
  input wire logic i_global_ie,
  input wire logic i_store_ready,
  input wire logic i_external_interrupt_zero,
  input wire logic i_pin_change,
  input wire logic i_reset_source,
  input wire logic [1:0] i_clock_source_select_fuses,
  input wire logic i_crystal_selected,
  input wire logic i_onchip_debug_enable_fuse,
  input wire logic i_converter_enable,
  input wire logic i_comparator_disable_bit,
  input wire logic i_comparator_uses_ref,
  input wire logic i_timer2_enable,
  input wire logic i_timer2_async,
  input wire logic i_display_enable,
  input wire logic i_display_async,
  input wire logic i_watchdog_enable,
  input wire logic i_brownout_enable,
  output smcg_pkg::smcg_clk_t o_clk_en,
  output smcg_pkg::smcg_analog_t o_analog,
  output logic [smcg_pkg::NUM_PERIPH-1:0] o_periph_clk_en,
  output logic [smcg_pkg::NUM_PERIPH-1:0] o_periph_access,
  output logic o_conv_start,
  output logic o_conv_extended,
  output logic o_core_hold,
  output logic o_resume,
  output logic o_reset_wake
);
  smcg_pkg::smcg_regs_t r_reg;
  smcg_pkg::smcg_regs_t r_next;

  default clocking cb_sys @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  logic [2:0] sel_mode;
  logic mode_legal;
  logic wake;
  logic ext0_sync;
  logic pinchg_sync;
  logic rst_src_sync;
  logic t2_evt;
  logic async_used;
  logic sync_used;
  logic sleeping;
  logic [smcg_pkg::CNT_W-1:0] restart_cyc;

  assign sel_mode = r_reg.ctrl[smcg_pkg::CTRL_MODE_LSB +: 3];
  assign ext0_sync = r_reg.pin_s2[0];
  assign pinchg_sync = r_reg.pin_s2[1];
  assign rst_src_sync = r_reg.pin_s2[2];
  assign sleeping = (r_reg.state == smcg_pkg::ST_SLEEP);
  assign t2_evt = i_global_ie & ((i_timer2_ovf & i_timer2_interrupt_mask[0]) |
                  (i_timer2_cmp & i_timer2_interrupt_mask[1]));
  assign async_used = (i_timer2_enable & i_timer2_async) | (i_display_enable & i_display_async);
  assign sync_used = (i_timer2_enable & ~i_timer2_async) | (i_display_enable & ~i_display_async);

  // reserved codes, and standby without a crystal, leave the core running
  always_comb begin
    unique case (sel_mode)
      smcg_pkg::MODE_IDLE, smcg_pkg::MODE_NOISE, smcg_pkg::MODE_PDOWN,
      smcg_pkg::MODE_PSAVE: mode_legal = 1'b1;
      smcg_pkg::MODE_STANDBY: mode_legal = i_crystal_selected; // see RULE13
      default: mode_legal = 1'b0; // see RULE25
    endcase
  end

  always_comb begin
    unique case (i_clock_source_select_fuses) // see RULE9
      2'h0: restart_cyc = smcg_pkg::RESTART_CYC_0;
      2'h1: restart_cyc = smcg_pkg::RESTART_CYC_1;
      2'h2: restart_cyc = smcg_pkg::RESTART_CYC_2;
      2'h3: restart_cyc = smcg_pkg::RESTART_CYC_3;
    endcase
  end

  // wake source selection per mode
  always_comb begin
    wake = 1'b0;
    if (r_reg.mode == smcg_pkg::MODE_IDLE) begin
      wake = i_irq_any | rst_src_sync; // see RULE2
    end else if (r_reg.mode == smcg_pkg::MODE_NOISE) begin
      wake = i_conv_done | rst_src_sync | i_display_irq | i_start_cond | t2_evt |
             i_store_ready | ext0_sync | pinchg_sync; // see RULE4
    end else if (r_reg.mode == smcg_pkg::MODE_PSAVE) begin
      wake = rst_src_sync | i_start_cond | ext0_sync | pinchg_sync |
             t2_evt | i_display_irq; // see RULE11
    end else begin
      wake = rst_src_sync | i_start_cond | ext0_sync | pinchg_sync; // see RULE7
    end
  end

  always_comb begin
    logic enter;
    logic [2:0] m;
    logic sl;
    logic io_on;
    logic conv_on;
    enter = 1'b0;
    m = 3'h0;
    sl = 1'b0;
    io_on = 1'b0;
    conv_on = 1'b0;
    r_next = r_reg;
    r_next.conv_start = 1'b0;
    r_next.resume = 1'b0;
    r_next.reset_wake = 1'b0;
    // pin wake inputs (line zero, pin change, reset source) pass two flops before use; see RULE8
    r_next.pin_s1 = {i_reset_source, i_pin_change, i_external_interrupt_zero};
    r_next.pin_s2 = r_reg.pin_s1;

    // register port
    r_next.rdata = 8'h00;
    if (i_write) begin
      if (i_addr == smcg_pkg::ADDR_CTRL) begin
        r_next.ctrl = {4'h0, i_wdata[3:0]};
      end else if (i_addr == smcg_pkg::ADDR_PRR) begin
        r_next.peripheral_clock_stop_register = i_wdata[smcg_pkg::NUM_PERIPH-1:0]; // see RULE15 see RULE16
      end
    end
    if (i_read) begin
      if (i_addr == smcg_pkg::ADDR_CTRL) begin
        r_next.rdata = r_reg.ctrl;
      end else if (i_addr == smcg_pkg::ADDR_PRR) begin
        r_next.rdata = {3'h0, r_reg.peripheral_clock_stop_register};
      end else if (i_addr == smcg_pkg::ADDR_STAT) begin
        r_next.rdata = {1'b0, r_reg.conv_ext, r_reg.mode, 1'b0, r_reg.state};
      end
    end

    // extended first conversion after the converter comes back on
    r_next.conv_en_prev = i_converter_enable;
    if (i_conv_done) begin
      r_next.conv_ext = 1'b0;
    end
    if (i_converter_enable & ~r_reg.conv_en_prev) begin
      r_next.conv_ext = 1'b1; // see RULE18
    end

    unique case (r_reg.state)
      smcg_pkg::ST_ACTIVE: begin
        enter = i_sleep_exec & r_reg.ctrl[smcg_pkg::CTRL_EN_BIT] & mode_legal; // see RULE23
        if (enter) begin
          r_next.state = smcg_pkg::ST_SLEEP;
          r_next.mode = sel_mode;
          if ((sel_mode == smcg_pkg::MODE_IDLE || sel_mode == smcg_pkg::MODE_NOISE) &&
              i_converter_enable) begin
            r_next.conv_start = 1'b1; // see RULE5
          end
        end
      end
      smcg_pkg::ST_SLEEP: begin
        if (wake && rst_src_sync) begin
          // reset wake goes back to the vector, no halt
          r_next.state = smcg_pkg::ST_ACTIVE;
          r_next.reset_wake = 1'b1; // see RULE24
        end else if (wake) begin
          r_next.state = smcg_pkg::ST_RESTART;
          if (r_reg.mode == smcg_pkg::MODE_STANDBY) begin
            r_next.count = smcg_pkg::CNT_W'(smcg_pkg::STANDBY_CYCLES - 1); // see RULE14
          end else if (r_reg.mode == smcg_pkg::MODE_PDOWN || r_reg.mode == smcg_pkg::MODE_PSAVE) begin
            r_next.count = restart_cyc - 12'h001; // see RULE9
          end else begin
            r_next.count = 12'h000;
          end
        end
      end
      smcg_pkg::ST_RESTART: begin
        if (r_reg.count == 12'h000) begin
          r_next.state = smcg_pkg::ST_HALT;
          r_next.count = smcg_pkg::CNT_W'(smcg_pkg::HALT_CYCLES - 1);
        end else begin
          r_next.count = r_reg.count - 12'h001;
        end
      end
      smcg_pkg::ST_HALT: begin
        if (r_reg.count == 12'h000) begin
          r_next.state = smcg_pkg::ST_ACTIVE;
          r_next.resume = 1'b1; // see RULE24
        end else begin
          r_next.count = r_reg.count - 12'h001;
        end
      end
    endcase

    // gating follows the next state so clocks change with the state
    sl = (r_next.state == smcg_pkg::ST_SLEEP);
    m = r_next.mode;
    io_on = ~sl || m == smcg_pkg::MODE_IDLE;
    conv_on = io_on || m == smcg_pkg::MODE_NOISE;
    r_next.clk.core = ~sl; // see RULE1
    r_next.clk.flash = ~sl;
    r_next.clk.io = io_on; // see RULE3
    r_next.clk.conv = conv_on;
    r_next.clk.asy = conv_on || (m == smcg_pkg::MODE_PSAVE && async_used); // see RULE10
    r_next.clk.main_osc = conv_on || m == smcg_pkg::MODE_STANDBY || // see RULE6
                          (m == smcg_pkg::MODE_PSAVE && sync_used) || // see RULE12
                          i_onchip_debug_enable_fuse; // see RULE22
    r_next.clk.timer_osc = async_used && (conv_on || m == smcg_pkg::MODE_PSAVE); // see RULE12
    // in power-save the sync clock reaches only timer 2 and the display
    r_next.clk.t2_disp = io_on || (m == smcg_pkg::MODE_PSAVE && sync_used); // see RULE12
    r_next.ana.comparator_off = i_comparator_disable_bit || ~conv_on; // see RULE19
    r_next.ana.ref_keep = i_comparator_uses_ref & ~i_comparator_disable_bit; // see RULE19
    r_next.ana.input_buf_en = conv_on; // see RULE21
    r_next.ana.wdt_run = i_watchdog_enable; // see RULE20
    r_next.ana.bod_run = i_brownout_enable; // see RULE20
    r_next.ana.conv_run = i_converter_enable; // see RULE18
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      r_reg <= '{state: smcg_pkg::ST_ACTIVE, mode: smcg_pkg::MODE_IDLE, count: '0,
                 ctrl: smcg_pkg::CTRL_RESET, peripheral_clock_stop_register: smcg_pkg::PRR_RESET, rdata: '0,
                 pin_s1: '0, pin_s2: '0, conv_en_prev: 1'b0, conv_ext: 1'b0,
                 conv_start: 1'b0, resume: 1'b0, reset_wake: 1'b0,
                 clk: '{default: 1'b1}, ana: '{comparator_off: 1'b0, ref_keep: 1'b0,
                 input_buf_en: 1'b1, wdt_run: 1'b0, bod_run: 1'b0, conv_run: 1'b0}};
    end else begin
      r_reg <= r_next;
    end
  end

  // stop bits act whenever the io clock runs; deeper modes have it stopped anyway
  genvar gi;
  generate
    for (gi = 0; gi < smcg_pkg::NUM_PERIPH; gi++) begin : g_periph
      assign o_periph_clk_en[gi] = r_reg.clk.io & ~r_reg.peripheral_clock_stop_register[gi]; // see RULE15 see RULE17
      assign o_periph_access[gi] = ~r_reg.peripheral_clock_stop_register[gi]; // see RULE15
    end
  endgenerate

  assign o_rdata = r_reg.rdata;
  assign o_clk_en = r_reg.clk;
  assign o_analog = r_reg.ana;
  assign o_conv_start = r_reg.conv_start;
  assign o_conv_extended = r_reg.conv_ext;
  assign o_core_hold = (r_reg.state != smcg_pkg::ST_ACTIVE);
  assign o_resume = r_reg.resume;
  assign o_reset_wake = r_reg.reset_wake;

  logic enter_now;
  assign enter_now = (r_reg.state == smcg_pkg::ST_ACTIVE) & i_sleep_exec &
                     r_reg.ctrl[smcg_pkg::CTRL_EN_BIT];
  logic deep_mode;
  assign deep_mode = sleeping && r_reg.mode != smcg_pkg::MODE_IDLE && r_reg.mode != smcg_pkg::MODE_NOISE;

  a_idle_gating: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE1
    enter_now && sel_mode == smcg_pkg::MODE_IDLE |=> sleeping && !o_clk_en.core && o_clk_en.io)
    else $error("idle gating wrong");
  a_noise_gating: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE3
    enter_now && sel_mode == smcg_pkg::MODE_NOISE |=> !o_clk_en.io && o_clk_en.conv && o_clk_en.asy)
    else $error("noise gating wrong");
  a_conv_autostart: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE5
    enter_now && sel_mode == smcg_pkg::MODE_IDLE && i_converter_enable |=> o_conv_start)
    else $error("no conversion start on entry");
  a_no_enable: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE23
    r_reg.state == smcg_pkg::ST_ACTIVE && i_sleep_exec && !r_reg.ctrl[0] |=> !sleeping)
    else $error("slept without enable");
  a_reserved_mode: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE25
    enter_now && (sel_mode == 3'h4 || sel_mode == 3'h5 || sel_mode == 3'h7) |=> !sleeping)
    else $error("reserved mode entered");
  a_standby_wake: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE14
    sleeping && r_reg.mode == smcg_pkg::MODE_STANDBY && wake && !rst_src_sync
    |=> o_core_hold [*5] ##1 o_core_hold [*5] ##1 o_resume)
    else $error("standby wake timing wrong");
  a_pdown_osc: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE6
    sleeping && r_reg.mode == smcg_pkg::MODE_PDOWN && !$past(i_onchip_debug_enable_fuse)
    |-> !o_clk_en.main_osc && !o_clk_en.asy)
    else $error("oscillator running in power-down");
  a_periph_stop: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE15
    i_write && i_addr == smcg_pkg::ADDR_PRR && i_wdata[0] |=> !o_periph_clk_en[0] && !o_periph_access[0])
    else $error("peripheral clock not stopped");
  a_input_buf: assert property (@(posedge i_clock) disable iff (i_rst) // see RULE21
    deep_mode |-> !o_analog.input_buf_en)
    else $error("input buffers left on");
  a_idle_wake: assert property (sleeping && r_reg.mode == smcg_pkg::MODE_IDLE && i_irq_any // see RULE2
    |=> r_reg.state == smcg_pkg::ST_RESTART)
    else $error("idle missed an interrupt");
  a_pdown_refuse: assert property (sleeping && r_reg.mode == smcg_pkg::MODE_PDOWN && !i_start_cond // see RULE7
    && !ext0_sync && !pinchg_sync && !rst_src_sync |=> sleeping)
    else $error("power-down left without a wake source");
  a_psave_timer: assert property (sleeping && r_reg.mode == smcg_pkg::MODE_PSAVE && i_global_ie // see RULE11
    && i_timer2_ovf && i_timer2_interrupt_mask[0] |=> !sleeping)
    else $error("power-save missed timer wake");
  a_halt_length: assert property (r_reg.state == smcg_pkg::ST_RESTART && r_reg.count == 12'h000 // see RULE24
    |=> o_core_hold [*4] ##1 o_resume)
    else $error("halt length wrong");
  a_reset_wake: assert property (sleeping && rst_src_sync // see RULE24
    |=> o_reset_wake && !o_core_hold)
    else $error("reset wake missed");
  // $past gives the inputs that the registered gating was computed from
  a_timer_osc: assert property (sleeping && r_reg.mode == smcg_pkg::MODE_PSAVE && !$past(async_used) // see RULE12
    |-> !o_clk_en.timer_osc)
    else $error("timer oscillator left running");
  a_sync_stop: assert property (sleeping && r_reg.mode == smcg_pkg::MODE_PSAVE && !$past(sync_used) // see RULE12
    && !$past(i_onchip_debug_enable_fuse) |-> !o_clk_en.main_osc && !o_clk_en.t2_disp)
    else $error("main source left running");
  a_debug_osc: assert property (sleeping && $past(i_onchip_debug_enable_fuse) // see RULE22
    |-> o_clk_en.main_osc)
    else $error("debug lost main clock");
  a_deep_comp: assert property (deep_mode // see RULE19
    |-> o_analog.comparator_off)
    else $error("comparator on in deep sleep");
  a_keep_monitors: assert property (sleeping // see RULE20
    |-> (o_analog.wdt_run || !$past(i_watchdog_enable)) && (o_analog.bod_run || !$past(i_brownout_enable)))
    else $error("monitor dropped in sleep");
  a_conv_keep: assert property (sleeping && $past(i_converter_enable) // see RULE18
    |-> o_analog.conv_run)
    else $error("converter dropped in sleep");
  a_ext_conv: assert property (i_converter_enable && !r_reg.conv_en_prev // see RULE18
    |=> o_conv_extended)
    else $error("extended conversion not flagged");
  a_periph_idle: assert property (sleeping && r_reg.mode == smcg_pkg::MODE_IDLE // see RULE17
    |-> o_periph_clk_en == ~r_reg.peripheral_clock_stop_register)
    else $error("stop bits ignored in idle");
  a_standby_xtal: assert property (enter_now && sel_mode == smcg_pkg::MODE_STANDBY && !i_crystal_selected // see RULE13
    |=> !sleeping)
    else $error("standby without crystal");

  c_idle_cycle: cover property (@(posedge i_clock) disable iff (i_rst)
    sleeping && r_reg.mode == smcg_pkg::MODE_IDLE ##[1:50] o_resume);
  c_psave_t2: cover property (@(posedge i_clock) disable iff (i_rst)
    sleeping && r_reg.mode == smcg_pkg::MODE_PSAVE && t2_evt);
  c_reset_wake: cover property (@(posedge i_clock) disable iff (i_rst) o_reset_wake);
  c_standby_wake: cover property (sleeping && r_reg.mode == smcg_pkg::MODE_STANDBY
    ##1 r_reg.state == smcg_pkg::ST_RESTART);
  c_pdown_wake: cover property (sleeping && r_reg.mode == smcg_pkg::MODE_PDOWN
    && i_start_cond);
endmodule

`default_nettype wire

// ==== testbench/smcg_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// core and wake sources; src: 0 irq, 1 conv done, 2 display, 3 start cond, 4 t2 ovf,
// 5 t2 cmp, 6 store ready, 7 line zero, 8 pin change, 9 reset source
module smcg_core_model (
  input wire logic i_clock,
  input wire logic i_resume,
  input wire logic i_reset_wake,
  output var logic o_sleep_exec,
  output var logic [9:0] o_src
);
  initial begin
    o_sleep_exec = 1'b0;
    o_src = 10'h000;
  end
  // levels kept until the core runs again, so a slow restart still sees them
  always @(posedge i_clock) begin
    if (i_resume || i_reset_wake) begin
      o_src <= 10'h000;
    end
  end
  task automatic sleep_now();
    @(posedge i_clock);
    o_sleep_exec <= 1'b1;
    @(posedge i_clock);
    o_sleep_exec <= 1'b0;
  endtask
  task automatic raise(input int idx);
    @(posedge i_clock);
    o_src[idx] <= 1'b1;
  endtask
  task automatic drop();
    @(posedge i_clock);
    o_src <= 10'h000;
  endtask
endmodule
`default_nettype wire

// ==== testbench/smcg_sleep_ctrl_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module smcg_sleep_ctrl_tb;
  logic i_clock, i_rst = 1'b1, i_write = 1'b0, i_read = 1'b0, i_brownout_enable = 1'b0;
  logic [1:0] i_addr = 2'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata, d;
  logic i_crystal_selected = 1'b0, i_onchip_debug_enable_fuse = 1'b0, i_converter_enable = 1'b1;
  logic i_timer2_enable = 1'b0, i_timer2_async = 1'b0, i_global_ie = 1'b0, i_watchdog_enable = 1'b1;
  logic [1:0] i_timer2_interrupt_mask = 2'h0;
  logic o_sleep_exec, o_conv_start, o_conv_extended, o_core_hold, o_resume, o_reset_wake;
  logic [9:0] src;
  logic [4:0] o_periph_clk_en, o_periph_access;
  smcg_pkg::smcg_clk_t o_clk_en;
  smcg_pkg::smcg_analog_t o_analog;
  logic [2:0] rsv [4] = '{3'h4, 3'h5, 3'h7, 3'h6};
  int error_cnt = 0, n_compared = 0, n_idle, n;

  smcg_sleep_ctrl i_smcg_sleep_ctrl (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_sleep_exec(o_sleep_exec), .i_irq_any(src[0]),
    .i_conv_done(src[1]), .i_display_irq(src[2]), .i_start_cond(src[3]), .i_timer2_ovf(src[4]),
    .i_timer2_cmp(src[5]), .i_timer2_interrupt_mask(i_timer2_interrupt_mask), .i_global_ie(i_global_ie),
    .i_store_ready(src[6]), .i_external_interrupt_zero(src[7]), .i_pin_change(src[8]),
    .i_reset_source(src[9]), .i_clock_source_select_fuses(2'h0), .i_crystal_selected(i_crystal_selected),
    .i_onchip_debug_enable_fuse(i_onchip_debug_enable_fuse), .i_converter_enable(i_converter_enable),
    .i_comparator_disable_bit(1'b0), .i_comparator_uses_ref(1'b1), .i_timer2_enable(i_timer2_enable),
    .i_timer2_async(i_timer2_async), .i_display_enable(1'b0), .i_display_async(1'b0),
    .i_watchdog_enable(i_watchdog_enable), .i_brownout_enable(i_brownout_enable), .o_clk_en(o_clk_en),
    .o_analog(o_analog), .o_periph_clk_en(o_periph_clk_en), .o_periph_access(o_periph_access),
    .o_conv_start(o_conv_start), .o_conv_extended(o_conv_extended), .o_core_hold(o_core_hold),
    .o_resume(o_resume), .o_reset_wake(o_reset_wake));
  smcg_core_model i_smcg_core_model (.i_clock(i_clock), .i_resume(o_resume), .i_reset_wake(o_reset_wake),
    .o_sleep_exec(o_sleep_exec), .o_src(src));

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  // generous: the whole run needs about five hundred cycles
  initial begin
    repeat (60000) @(posedge i_clock);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end

  task automatic report_and_stop();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge i_clock);
    i_write <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge i_clock);
    i_read <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1;
    v = o_rdata;
  endtask
  task automatic settle();
    repeat (2) @(posedge i_clock);
    #1;
  endtask
  task automatic enter(input logic [2:0] m);
    wr(smcg_pkg::ADDR_CTRL, {4'h0, m, 1'b1});
    i_smcg_core_model.sleep_now();
    #1;
  endtask
  // cycles from raising a source until the core is released
  task automatic wake(input int idx, output int cnt);
    i_smcg_core_model.raise(idx);
    cnt = 0;
    do begin
      @(posedge i_clock);
      #1;
      cnt++;
    end while (o_resume !== 1'b1 && o_reset_wake !== 1'b1 && cnt < 5000);
    chk(8'(cnt < 5000), 8'h01);
  endtask
  task automatic no_wake(input int idx);
    i_smcg_core_model.raise(idx);
    repeat (20) @(posedge i_clock);
    #1;
    chk({7'h0, o_core_hold}, 8'h01);
    i_smcg_core_model.drop();
  endtask

  initial begin
    repeat (10) @(posedge i_clock);
    #1;
    chk(o_clk_en, 8'hff);
    chk({3'h0, o_periph_clk_en}, 8'h1f);
    repeat (10) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(smcg_pkg::ADDR_CTRL, d);
    chk(d, smcg_pkg::CTRL_RESET);
    rd(smcg_pkg::ADDR_PRR, d);
    chk(d, {3'h0, smcg_pkg::PRR_RESET});
    rd(smcg_pkg::ADDR_STAT, d);
    chk(d, 8'h40);
    wr(smcg_pkg::ADDR_CTRL, 8'hff);
    rd(smcg_pkg::ADDR_CTRL, d);
    chk(d, 8'h0f);
    wr(2'h3, 8'hff);
    rd(2'h3, d);
    chk(d, 8'h00);
    wr(smcg_pkg::ADDR_PRR, 8'hff);
    rd(smcg_pkg::ADDR_PRR, d);
    chk(d, 8'h1f);
    wr(smcg_pkg::ADDR_CTRL, 8'h00);
    i_smcg_core_model.sleep_now();
    #1;
    chk({7'h0, o_core_hold}, 8'h00);
    foreach (rsv[k]) begin
      enter(rsv[k]);
      chk({7'h0, o_core_hold}, 8'h00);
    end
    wr(smcg_pkg::ADDR_PRR, 8'h05);
    settle();
    chk({3'h0, o_periph_clk_en}, 8'h1a);
    chk({3'h0, o_periph_access}, 8'h1a);
    enter(smcg_pkg::MODE_IDLE);
    chk({7'h0, o_conv_start}, 8'h01);
    chk({2'h0, o_clk_en[7:2]}, 8'h0f);
    settle();
    chk({3'h0, o_periph_clk_en}, 8'h1a);
    chk({3'h0, o_analog[5], o_analog[3:0]}, 8'h0d);
    wake(0, n_idle);
    chk(8'(n_idle <= smcg_pkg::HALT_CYCLES + 3), 8'h01);
    chk({7'h0, o_core_hold}, 8'h00);
    enter(smcg_pkg::MODE_NOISE);
    chk({7'h0, o_conv_start}, 8'h01);
    chk({2'h0, o_clk_en[7:2]}, 8'h07);
    settle();
    chk({3'h0, o_periph_clk_en}, 8'h00);
    no_wake(0);
    wake(1, n);
    wr(smcg_pkg::ADDR_PRR, 8'h00);
    i_brownout_enable <= 1'b1;
    settle();
    chk({3'h0, o_periph_clk_en}, 8'h1f);
    enter(smcg_pkg::MODE_PDOWN);
    chk({2'h0, o_clk_en[7:2]}, 8'h00);
    settle();
    chk({2'h0, o_analog}, 8'h37);
    no_wake(0);
    no_wake(2);
    wake(3, n);
    chk(8'(n - n_idle), 8'(smcg_pkg::RESTART_CYC_0 - 12'h1));
    @(posedge i_clock);
    i_timer2_enable <= 1'b1;
    i_timer2_async <= 1'b1;
    i_timer2_interrupt_mask <= 2'h1;
    enter(smcg_pkg::MODE_PSAVE);
    chk(o_clk_en, 8'h0a);
    no_wake(4);
    i_global_ie <= 1'b1;
    wake(4, n);
    @(posedge i_clock);
    i_crystal_selected <= 1'b1;
    enter(smcg_pkg::MODE_STANDBY);
    chk({2'h0, o_clk_en[7:2]}, 8'h01);
    wake(3, n);
    chk(8'(n - n_idle), 8'(smcg_pkg::STANDBY_CYCLES - 1));
    @(posedge i_clock);
    i_onchip_debug_enable_fuse <= 1'b1;
    enter(smcg_pkg::MODE_PDOWN);
    chk({7'h0, o_clk_en.main_osc}, 8'h01);
    wake(9, n);
    chk({7'h0, o_reset_wake}, 8'h01);
    settle();
    chk({7'h0, o_core_hold}, 8'h00);
    chk({7'h0, o_conv_extended}, 8'h00);
    @(posedge i_clock);
    i_converter_enable <= 1'b0;
    @(posedge i_clock);
    i_converter_enable <= 1'b1;
    settle();
    chk({7'h0, o_conv_extended}, 8'h01);
    report_and_stop();
  end
endmodule
`default_nettype wire
